// [fpc_flash_cmd.sv]
// command logic: page-size configuration, id read and software reset
// assumes spi modes 0/3 from the host, pins sampled on ref_clk; the
// nonvolatile cell is modelled by the cfgBinary flop plus nvStore strap
// limitations
//   only four command families are decoded here; every other opcode
//   falls into the ignore state and waits for the next cs rise
//   the status read shows ready/busy only, repeated on every bit, so a
//   host that expects the full status byte layout sees busy in each bit
//   the pin inputs are oversampled, so sck may not toggle faster than
//   one edge per four ref_clk cycles, or edges are merged and lost
//   the id read needs a slow clock for the same reason
//
// trade-offs
//   all state lives in one packed record so that reset and hold behaviour
//   is uniform; the price is one wide register that is hard to read in
//   a waveform without the struct view
//   the program and reset timers share one down counter; a configuration
//   program started during a soft reset reloads it, and a soft reset takes over the counter
//   and ends a running configuration program with the old size in place
//
module fpc_flash_cmd
  import fpc_pkg::*;
#(
  parameter int          CFG_CYCLES  = CFG_CYC,  // config program time in cycles
  parameter int          SRST_CYCLES = SRST_CYC, // soft reset time in cycles
  parameter logic [7:0]  MFR_ID      = 8'h5a,    // arbitrary value
  parameter logic [2:0]  FAMILY_CODE = 3'h3,     // arbitrary value
  parameter logic [4:0]  DENSITY     = 5'h0a,    // arbitrary value
  parameter logic [2:0]  SUB_CODE    = 3'h0,     // arbitrary value
  parameter logic [4:0]  VARIANT     = 5'h00,    // arbitrary value
  parameter logic [4:0]  REVISION    = 5'h00     // arbitrary value
) (
  input  wire logic       ref_clk,                      // system clock
  input  wire logic       srst,                         // sync reset, high
  input  wire logic       csN,                          // chip select pin, low
  input  wire logic       sck,                          // spi clock pin
  input  wire logic       si,                           // serial data in pin
  output logic            so,                           // serial data out
  output logic            soOe,                         // output enable
  input  wire logic       nvStore,                      // stored size, 1 binary
  input  wire logic       opRunning,                    // array program/erase on
  input  wire logic       suspendSet1,                  // buffer one suspended event
  input  wire logic       suspendSet2,                  // buffer two suspended event
  input  wire logic       eraseSuspendSet,              // erase suspended event
  output logic            busy,                         // ready/busy, 1 busy
  output logic            cfgBinary,                    // 1: 256 byte pages
  output logic [8:0]      pageSize,                     // bytes per page
  output logic            abortOp,                      // stop program/erase
  output logic            buffer_one_program_suspended, // status flag
  output logic            buffer_two_program_suspended, // status flag
  output logic            erase_suspended_flag,         // status flag
  output logic            nvWrite                       // pulse: commit to cell
);
  // ==========================================================================
  // state record
  typedef struct packed {
    logic [1:0] csS;      // cs synchroniser
    logic [1:0] sckS;     // sck synchroniser
    logic [1:0] siS;      // si synchroniser
    logic       csQ;      // cs after sync, delayed
    logic       sckQ;     // sck after sync, delayed
    fpc_state_e st;       // command state
    logic [2:0] bitCnt;   // bit in byte
    logic [2:0] byteCnt;  // byte in command
    logic [7:0] shIn;     // input shifter
    logic       seqCfg;   // sequence is configuration
    fpc_pend_e  pend;     // action armed for cs rise
    logic [7:0] shOut;    // output shifter
    logic       so;       // output bit
    logic       soOe;     // drive enable
    logic       cfgBin;   // active page size
    logic       cfgNew;   // size being programmed
    logic       loaded;   // stored size fetched
    logic       cfgBusy;  // config program running
    logic       rstBusy;  // soft reset running
    logic [31:0] tmr;     // program/reset timer
    logic       nvW;      // commit pulse
    logic       ps1;      // buffer one suspended
    logic       ps2;      // buffer two suspended
    logic       es;       // erase suspended
  } fpc_s;

  fpc_s cur_r;
  fpc_s cur_nxt;

  // ==========================================================================
  // id string
  // byte at given index of the id string; index four and above gives the
  // extended byte, the caller stops the stream before it runs past it
  function automatic logic [7:0] idByte(input logic [2:0] idx);
    unique case (idx)
      3'h0:    idByte = MFR_ID;
      3'h1:    idByte = {FAMILY_CODE, DENSITY};
      3'h2:    idByte = {SUB_CODE, VARIANT};
      3'h3:    idByte = EDI_LEN;
      default: idByte = {RESERVED_UPPER, REVISION};
    endcase
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    logic       csLow;
    logic       sckRise;
    logic       sckFall;
    logic       csRise;
    logic [7:0] byteIn;
    logic       lastBit;
    logic [7:0] idCur;
    csLow   = 1'b0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    csRise  = 1'b0;
    byteIn  = 8'h00;
    lastBit = 1'b0;
    idCur   = 8'h00;
    cur_nxt = cur_r;
    // ------------------------------------------------------------------------
    // pin sampling
    // every pin passes two flops before any decision reads it; the extra
    // delayed copy of cs and sck gives the edge detectors their old value
    // only stage two is read, stage one feeds it alone
    cur_nxt.csS  = {cur_r.csS[0], csN};
    cur_nxt.sckS = {cur_r.sckS[0], sck};
    cur_nxt.siS  = {cur_r.siS[0], si};
    cur_nxt.csQ  = cur_r.csS[1];
    cur_nxt.sckQ = cur_r.sckS[1];
    csLow   = ~cur_r.csS[1];
    sckRise = csLow & cur_r.sckS[1] & ~cur_r.sckQ;
    sckFall = csLow & ~cur_r.sckS[1] & cur_r.sckQ;
    csRise  = cur_r.csS[1] & ~cur_r.csQ;
    byteIn  = {cur_r.shIn[6:0], cur_r.siS[1]};
    lastBit = (cur_r.bitCnt == 3'h7);
    idCur   = idByte(cur_r.byteCnt - 3'h1);
    // commit pulse lasts exactly one cycle
    cur_nxt.nvW = 1'b0;
    // stored size fetched once after reset, then held here
    if (!cur_r.loaded) begin
      cur_nxt.cfgBin = nvStore;
      cur_nxt.loaded = 1'b1;
    end
    // suspend flags: hardware set, reset clears; set wins over a soft reset
    if (suspendSet1) cur_nxt.ps1 = 1'b1;
    if (suspendSet2) cur_nxt.ps2 = 1'b1;
    if (eraseSuspendSet) cur_nxt.es = 1'b1;
    // ------------------------------------------------------------------------
    // timed program and reset cycles
    // the counter is loaded with the length minus one, so busy stands for
    // exactly the configured number of cycles; the new size is taken over
    // in the cycle in which busy falls, never earlier
    if (cur_r.cfgBusy || cur_r.rstBusy) begin
      if (cur_r.tmr == 32'h0) begin
        if (cur_r.cfgBusy) begin
          cur_nxt.cfgBin = cur_r.cfgNew;
          cur_nxt.nvW    = 1'b1;
        end
        cur_nxt.cfgBusy = 1'b0;
        cur_nxt.rstBusy = 1'b0;
      end else begin
        cur_nxt.tmr = cur_r.tmr - 32'h1;
      end
    end
    // ------------------------------------------------------------------------
    // serial input on rising sck
    // the byte counter saturates so that a long frame cannot wrap back
    // onto the sequence positions and fire a command a second time
    if (sckRise) begin
      cur_nxt.shIn   = byteIn;
      cur_nxt.bitCnt = cur_r.bitCnt + 3'h1;
      if (lastBit) begin
        if (cur_r.byteCnt != 3'h7) cur_nxt.byteCnt = cur_r.byteCnt + 3'h1;
        unique case (cur_r.st)
          ST_CMD: begin
            if (byteIn == OP_CFG0 && !cur_r.cfgBusy) begin
              cur_nxt.st = ST_SEQ;
              cur_nxt.seqCfg = 1'b1;
            end else if (byteIn == OP_SRST) begin
              cur_nxt.st = ST_SEQ;
              cur_nxt.seqCfg = 1'b0;
            end else if (byteIn == OP_ID_READ && !cur_r.cfgBusy) begin
              cur_nxt.st = ST_ID;
            end else if (byteIn == OP_STATUS) begin
              cur_nxt.st = ST_STAT;
            end else begin
              cur_nxt.st = ST_IGN;
            end
          end
          ST_SEQ: begin
            if (cur_r.seqCfg) begin
              if (cur_r.byteCnt == 3'h1 && byteIn == OP_CFG1) begin
                cur_nxt.st = ST_SEQ;
              end else if (cur_r.byteCnt == 3'h2 && byteIn == OP_CFG2) begin
                cur_nxt.st = ST_SEQ;
              end else if (cur_r.byteCnt == 3'h3 && byteIn == OP_CFG_BIN) begin
                cur_nxt.pend = PEND_BIN;
                cur_nxt.st = ST_IGN;
              end else if (cur_r.byteCnt == 3'h3 && byteIn == OP_CFG_STD) begin
                cur_nxt.pend = PEND_STD;
                cur_nxt.st = ST_IGN;
              end else begin
                cur_nxt.st = ST_IGN;
              end
            end else if (byteIn != OP_ZERO) begin
              cur_nxt.st = ST_IGN;
            end else if (cur_r.byteCnt == 3'h3) begin
              cur_nxt.pend = PEND_SRST;
              cur_nxt.st = ST_IGN;
            end
          end
          default: begin
          end
        endcase
      end else if (cur_r.st == ST_IGN && cur_r.pend == PEND_SRST) begin
        cur_nxt.pend = PEND_SRST;
      end
      // a later bit after a soft reset sequence is still not a boundary
    end
    // ------------------------------------------------------------------------
    // serial output changes on falling sck
    // a new byte is loaded at bit zero of each of the five id bytes after the opcode; the
    // host samples on the rising edge, half a period later
    if (sckFall && cur_r.st == ST_ID) begin
      if (cur_r.bitCnt == 3'h0) begin
        if (cur_r.byteCnt <= 3'(ID_BYTES)) begin
          cur_nxt.so    = idCur[7];
          cur_nxt.shOut = {idCur[6:0], 1'b0};
          cur_nxt.soOe  = 1'b1;
        end else begin
          cur_nxt.soOe  = 1'b0;
        end
      end else begin
        cur_nxt.so    = cur_r.shOut[7];
        cur_nxt.shOut = {cur_r.shOut[6:0], 1'b0};
      end
    end
    // status read: busy from our own timers or from the array engine
    if (sckFall && cur_r.st == ST_STAT) begin
      cur_nxt.so   = cur_r.cfgBusy | cur_r.rstBusy | opRunning;
      cur_nxt.soOe = 1'b1;
    end
    // ------------------------------------------------------------------------
    // cs rise ends the frame and fires an armed action
    // the armed action is dropped when cs rises off a byte boundary, so a
    // cut frame never starts a program or a reset
    if (csRise) begin
      cur_nxt.soOe    = 1'b0;
      cur_nxt.st      = ST_CMD;
      cur_nxt.bitCnt  = 3'h0;
      cur_nxt.byteCnt = 3'h0;
      cur_nxt.pend    = PEND_NONE;
      if (cur_r.bitCnt == 3'h0) begin
        unique case (cur_r.pend)
          PEND_BIN, PEND_STD: begin
            cur_nxt.cfgNew  = (cur_r.pend == PEND_BIN);
            cur_nxt.cfgBusy = 1'b1;
            cur_nxt.tmr     = 32'(CFG_CYCLES - 1);
          end
          PEND_SRST: begin
            // page size stays as it is
            cur_nxt.cfgBusy = 1'b0;
            cur_nxt.rstBusy = 1'b1;
            cur_nxt.tmr     = 32'(SRST_CYCLES - 1);
            cur_nxt.ps1     = suspendSet1;
            cur_nxt.ps2     = suspendSet2;
            cur_nxt.es      = eraseSuspendSet;
          end
          default: begin
          end
        endcase
      end
    end
    // ------------------------------------------------------------------------
    // synchronous reset wins over everything; cs and its delayed copy come
    // up high so that no false cs edge follows reset
    if (srst) begin
      cur_nxt = '0;
      cur_nxt.csS = 2'h3;
      cur_nxt.csQ = 1'b1;
      cur_nxt.st = ST_CMD;
      cur_nxt.pend = PEND_NONE;
      cur_nxt.cfgBin = CFG_BIN_RST;
    end
  end

  // ==========================================================================
  // one register for all state
  // no reset branch here: reset values are chosen in the next-state logic
  always_ff @(posedge ref_clk) begin
    cur_r <= cur_nxt;
  end

  // ==========================================================================
  // outputs; abort lasts the reset time unless a config program reloads the timer, page data then undefined
  // busy is combinational from registers so it has no extra cycle of lag
  // behind the timer; page size follows the active size flag directly
  assign so        = cur_r.so;
  assign soOe      = cur_r.soOe;
  assign busy      = cur_r.cfgBusy | cur_r.rstBusy;
  assign cfgBinary = cur_r.cfgBin;
  assign pageSize  = cur_r.cfgBin ? PAGE_BIN : PAGE_STD;
  assign abortOp   = cur_r.rstBusy;
  assign buffer_one_program_suspended = cur_r.ps1;
  assign buffer_two_program_suspended = cur_r.ps2;
  assign erase_suspended_flag         = cur_r.es;
  assign nvWrite   = cur_r.nvW;
endmodule

// [fpc_pkg.sv]
// package for the page-size configuration, id read and soft reset command logic
// assumes a 40 MHz ref_clk that oversamples the host's spi clock
package fpc_pkg;
  // ==========================================================================
  // opcodes and sequence bytes
  localparam logic [7:0] OP_CFG0      = 8'h3d;
  localparam logic [7:0] OP_CFG1      = 8'h2a;
  localparam logic [7:0] OP_CFG2      = 8'h80;
  localparam logic [7:0] OP_CFG_BIN   = 8'ha6;
  localparam logic [7:0] OP_CFG_STD   = 8'ha7;
  localparam logic [7:0] OP_ID_READ   = 8'h9f;
  localparam logic [7:0] OP_SRST      = 8'hf0;
  localparam logic [7:0] OP_ZERO      = 8'h00;
  localparam logic [7:0] OP_STATUS    = 8'hd7;
  // ==========================================================================
  // id layout
  localparam logic [7:0] EDI_LEN      = 8'h01;
  localparam int         FAMILY_LSB   = 5;
  localparam int         REV_MSB      = 4;
  localparam logic [2:0] RESERVED_UPPER = 3'h0;
  localparam int         ID_BYTES     = 5;
  // ==========================================================================
  // page sizes and reset values
  localparam logic [8:0] PAGE_BIN     = 9'h100;
  localparam logic [8:0] PAGE_STD     = 9'h108;
  localparam logic       CFG_BIN_RST  = 1'b0;
  // ==========================================================================
  // timing
  localparam int CLK_MHZ              = 40;
  localparam int CONFIG_PROGRAM_TIME_US = 50000;
  localparam int SOFT_RESET_TIME_US   = 35;
  localparam int CFG_CYC = CONFIG_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SRST_CYC = SOFT_RESET_TIME_US * CLK_MHZ;
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_CMD  = 3'h0,
    ST_SEQ  = 3'h1,
    ST_ID   = 3'h2,
    ST_STAT = 3'h3,
    ST_IGN  = 3'h4
  } fpc_state_e;
  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_BIN  = 2'h1,
    PEND_STD  = 2'h2,
    PEND_SRST = 2'h3
  } fpc_pend_e;
endpackage

// [fpc_flash_cmd_monitor.sv]
// port assertions for the page-size, id read and soft reset command block
// bound into fpc_flash_cmd; counts follow the bound instance's parameters
module fpc_flash_cmd_monitor
  import fpc_pkg::*;
#(
  parameter int CFG_CYCLES  = CFG_CYC,  // config program cycles
  parameter int SRST_CYCLES = SRST_CYC  // soft reset cycles
) (
  input wire logic       ref_clk,                      // clock
  input wire logic       srst,                         // sync reset
  input wire logic       csN,                          // chip select
  input wire logic       soOe,                         // so drive enable
  input wire logic       busy,                         // ready/busy
  input wire logic       cfgBinary,                    // size select
  input wire logic [8:0] pageSize,                     // page bytes
  input wire logic       abortOp,                      // soft reset window
  input wire logic       buffer_one_program_suspended, // flag
  input wire logic       buffer_two_program_suspended, // flag
  input wire logic       erase_suspended_flag,         // flag
  input wire logic       nvWrite                       // commit pulse
);
  // ==========================================================
  // run counters: long counts cannot be written as repetitions
  int busyRun_r;  // busy cycles in this run
  int abortRun_r; // abort cycles in this run
  always_ff @(posedge ref_clk) begin
    busyRun_r  <= (srst || !busy) ? 0 : busyRun_r + 1;
    abortRun_r <= (srst || !abortOp) ? 0 : abortRun_r + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // properties
  property p_page; pageSize == (cfgBinary ? PAGE_BIN : PAGE_STD); endproperty
  a_page: assert property (p_page) else $error("page size off");
  property p_boot; $fell(srst) |-> pageSize == PAGE_STD && !busy && !abortOp; endproperty
  a_boot: assert property (p_boot) else $error("reset values off");
  property p_commit; nvWrite |=> !nvWrite; endproperty
  a_commit: assert property (p_commit) else $error("commit not a pulse");
  property p_release; csN [*6] |-> !soOe; endproperty
  a_release: assert property (p_release) else $error("so driven while deselected");
  property p_busy_min; $rose(busy) |-> busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_max; busyRun_r <= CFG_CYCLES; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_abort_max; abortRun_r <= SRST_CYCLES; endproperty
  a_abort_max: assert property (p_abort_max) else $error("abort too long");
  property p_flags;
    $rose(abortOp) |-> ##[0:1] !(buffer_one_program_suspended
      || buffer_two_program_suspended || erase_suspended_flag);
  endproperty
  a_flags: assert property (p_flags) else $error("suspend flags kept");
  property p_size_kept; abortOp |-> $stable(cfgBinary); endproperty
  a_size_kept: assert property (p_size_kept) else $error("size changed by reset");
endmodule
bind fpc_flash_cmd fpc_flash_cmd_monitor #(
  .CFG_CYCLES(CFG_CYCLES), .SRST_CYCLES(SRST_CYCLES)
) u_mon (.ref_clk, .srst, .csN, .soOe, .busy, .cfgBinary, .pageSize, .abortOp,
  .buffer_one_program_suspended, .buffer_two_program_suspended,
  .erase_suspended_flag, .nvWrite);

// [fpc_spi_host.sv]
// host spi controller model, mode 0, on the command pins
// assumes a 40 MHz bench clock; one sck period is 8 of its cycles
module fpc_spi_host (
  input  wire logic ref_clk, // bench clock
  input  wire logic so,      // device data out
  input  wire logic soOe,    // device drive enable
  output logic      csN,     // chip select, low
  output logic      sck,     // spi clock
  output logic      si       // data to device
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // idle pins: deselected, clock parked low between frames
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end
  // one frame of n bits msb first from d[63]; so sampled a cycle after each rise
  task automatic xfer(input logic [63:0] d, input int n, output logic [63:0] rx,
                      output logic [63:0] oe);
    rx = '0;
    oe = '0;
    @(posedge ref_clk);
    csN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si <= d[63-i];
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      @(posedge ref_clk);
      rx[63-i] = so;
      oe[63-i] = soOe;
      repeat (3) @(posedge ref_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    csN <= 1'b1;
    si  <= ~si; // released line shows the inverse, never a stale level
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// [tb_top.sv]
// self-checking bench for fpc_flash_cmd with shortened program times
// needs fpc_spi_host as the host and the bound port monitor
module tb_top
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         CFG  = 200;           // shortened program time
  localparam int         SRT  = 10;            // shortened soft reset time
  localparam logic [7:0] MFR  = 8'hc3;         // arbitrary value
  localparam logic [7:0] DEV1 = {3'h5, 5'h0b}; // arbitrary value
  localparam logic [7:0] DEV2 = {3'h2, 5'h06}; // arbitrary value
  localparam logic [4:0] REV  = 5'h09;         // arbitrary value
  logic ref_clk, srst, csN, sck, si, so, soOe, nvStore, opRunning, set1, set2, setE;
  logic busy, cfgBinary, abortOp, susp1, susp2, suspE, nvWrite;
  logic [8:0]  pageSize;  // bytes per page
  logic [63:0] rx, oe;    // last frame's samples
  int failCount, checks, busyCnt = 0, abortCnt = 0, nvCnt = 0, b0, a0, n0;
  int bad[2] = '{35, 24}; // off-boundary and short reset frames
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // running totals let a check see pulses that end inside a frame
  always @(posedge ref_clk) begin
    busyCnt  <= busyCnt + int'(busy);
    abortCnt <= abortCnt + int'(abortOp);
    nvCnt    <= nvCnt + int'(nvWrite);
  end
  fpc_flash_cmd #(.CFG_CYCLES(CFG), .SRST_CYCLES(SRT), .MFR_ID(MFR), .FAMILY_CODE(DEV1[7:5]),
    .DENSITY(DEV1[4:0]), .SUB_CODE(DEV2[7:5]), .VARIANT(DEV2[4:0]), .REVISION(REV)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe),
    .nvStore(nvStore), .opRunning(opRunning), .suspendSet1(set1), .suspendSet2(set2),
    .eraseSuspendSet(setE), .busy(busy), .cfgBinary(cfgBinary), .pageSize(pageSize),
    .abortOp(abortOp), .buffer_one_program_suspended(susp1),
    .buffer_two_program_suspended(susp2), .erase_suspended_flag(suspE), .nvWrite(nvWrite));
  fpc_spi_host u_host (.ref_clk(ref_clk), .so(so), .soOe(soOe), .csN(csN), .sck(sck), .si(si));
  // ==========================================================
  // tasks
  task automatic stop_test();
    if (failCount == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic send(input logic [63:0] d, input int n);
    b0 = busyCnt;
    a0 = abortCnt;
    n0 = nvCnt;
    u_host.xfer(d, n, rx, oe);
  endtask
  // bounded wait for the timed work to end
  task automatic settle();
    for (int i = 0; i < 400 && (busy !== 1'b0 || abortOp !== 1'b0); i++) @(posedge ref_clk);
    chk(busy, 0, "busy stuck");
    if (busy !== 1'b0) stop_test();
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic do_reset(input logic nv);
    nvStore <= nv;
    srst    <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {srst, nvStore, opRunning, set1, set2, setE} = 6'h20;
    @(posedge ref_clk);
    do_reset(1'b0);
    chk(pageSize, PAGE_STD, "default size");
    send({OP_ID_READ, 56'h0}, 56);
    chk(rx[55:16], {MFR, DEV1, DEV2, EDI_LEN, RESERVED_UPPER, REV}, "id bytes");
    chk(oe[55:16], {40{1'b1}}, "id not driven");
    chk(oe[15:8], 0, "driven after edi");
    send({OP_ID_READ, 56'h0}, 11);
    chk(soOe, 0, "not released on deselect");
    send({OP_CFG0, OP_CFG1, 8'h81, OP_CFG_BIN, 32'h0}, 32);
    settle();
    chk(busyCnt - b0, 0, "bad sequence ran");
    send({OP_CFG0, OP_CFG1, OP_CFG2, OP_CFG_BIN, 32'h0}, 32);
    u_host.xfer({OP_STATUS, 56'h0}, 16, rx, oe);
    chk(rx[55:48], 8'hff, "status not busy");
    settle();
    chk(busyCnt - b0, CFG, "program time");
    chk(nvCnt - n0, 1, "commit count");
    chk(pageSize, PAGE_BIN, "binary size");
    opRunning <= 1'b1;
    {set1, set2, setE} <= 3'b111;
    @(posedge ref_clk);
    {set1, set2, setE} <= 3'b000;
    @(posedge ref_clk);
    chk({susp1, susp2, suspE}, 3'b111, "flags not set");
    send({OP_SRST, 24'h0, 8'h5a, 24'h0}, 40);
    settle();
    chk(abortCnt - a0, SRT, "abort time");
    chk({susp1, susp2, suspE}, 0, "flags kept");
    chk(cfgBinary, 1, "size lost");
    foreach (bad[k]) begin
      send({OP_SRST, 56'h0}, bad[k]);
      settle();
      chk(abortCnt - a0, 0, "partial reset ran");
    end
    send({OP_CFG0, OP_CFG1, OP_CFG2, OP_CFG_STD, 32'h0}, 32);
    settle();
    chk(pageSize, PAGE_STD, "standard size");
    do_reset(1'b1);
    chk(cfgBinary, 1, "stored size not loaded");
    stop_test();
  end
endmodule
